/* File: hdl/rail_status_fault_regs.sv */
// Purpose: Power-good and power-fault status registers of the rail manager
// Assumes: Byte register port driven by the serial bus engine outside
// Notes:   Read data is registered, valid one cycle after the read strobe
//
// Function
// - Power-good two sits at B1h, is read-only, resets to zero, bits 7:6 read zero.
// - Bit 5 of power-good two shows the five-volt regulator in regulation.
// - Bit 4 of power-good two shows aux regulator one in regulation.
// - Bit 3 of power-good two shows the termination regulator in regulation.
// - Bit 2 of power-good two shows load switch B two in regulation.
// - Bit 1 of power-good two shows load switch B one in regulation.
// - Bit 0 of power-good two shows aux regulator three in regulation.
// - Fault one sits at B2h, resets to zero, all eight bits are fault flags.
// - Bit 7 of fault one sets when aux regulator two loses regulation.
// - Bit 6 of fault one sets when load switch A one loses regulation.
// - Bits 5 to 0 of fault one flag step-down rails six to one.
// - A fault flag clears only on reset or when the host writes 1 to its bit.
// - Fault two sits at B3h, resets to zero, bits 7:5 are reserved read-only.
// - Bits 4 to 0 of fault two flag aux one, termination, switch B two, B one, aux three.
`timescale 1ns/100ps
`default_nettype none
module rail_status_fault_regs (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  // Register port
  input  wire logic [7:0] i_addr,
  input  wire logic       i_wr_en,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_rd_en,
  output logic      [7:0] o_rd_data,
  output logic            o_rd_hit,
  // Live regulation status, high while in range
  input  wire logic       i_five_volt_reg_good,
  input  wire logic       i_aux_reg_one_good,
  input  wire logic       i_termination_good,
  input  wire logic       i_switch_b_two_good,
  input  wire logic       i_switch_b_one_good,
  input  wire logic       i_aux_reg_three_good,
  // Loss-of-regulation events, high while out of range
  input  wire logic       i_aux_reg_two_fault,
  input  wire logic       i_switch_a_one_fault,
  input  wire logic [5:0] i_step_down_fault,
  input  wire logic       i_aux_reg_one_fault,
  input  wire logic       i_termination_fault,
  input  wire logic       i_switch_b_two_fault,
  input  wire logic       i_switch_b_one_fault,
  input  wire logic       i_aux_reg_three_fault,
  // Flag state for pins or interrupt logic elsewhere
  output logic      [7:0] o_power_fault_status_one,
  output logic      [7:0] o_power_fault_status_two
);

  logic [7:0] good_reg;
  logic [7:0] good_next;
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  logic       rd_hit_reg;
  logic       rd_hit_next;
  logic [7:0] fault_one_in;
  logic [7:0] fault_two_in;
  logic       wr_fault_one;
  logic       wr_fault_two;

  // Power-good is sampled so a read sees a stable byte
  always_comb begin
    good_next = 8'h00;
    good_next[rail_status_pkg::FIVE_VOLT_REG_GOOD_BIT] = i_five_volt_reg_good;
    good_next[rail_status_pkg::AUX_REG_ONE_GOOD_BIT]   = i_aux_reg_one_good;
    good_next[rail_status_pkg::TERMINATION_GOOD_BIT]   = i_termination_good;
    good_next[rail_status_pkg::SWITCH_B_TWO_GOOD_BIT]  = i_switch_b_two_good;
    good_next[rail_status_pkg::SWITCH_B_ONE_GOOD_BIT]  = i_switch_b_one_good;
    good_next[rail_status_pkg::AUX_REG_THREE_GOOD_BIT] = i_aux_reg_three_good;
    good_next = good_next & rail_status_pkg::POWER_GOOD_STATUS_TWO_MASK;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      good_reg <= rail_status_pkg::POWER_GOOD_STATUS_TWO_RST;
    end else begin
      good_reg <= good_next;
    end
  end

  // Fault event vectors
  always_comb begin
    fault_one_in = 8'h00;
    fault_one_in[rail_status_pkg::AUX_REG_TWO_FAULT_BIT]  = i_aux_reg_two_fault;
    fault_one_in[rail_status_pkg::SWITCH_A_ONE_FAULT_BIT] = i_switch_a_one_fault;
    fault_one_in[rail_status_pkg::STEP_DOWN_SIX_FAULT_BIT:
                 rail_status_pkg::STEP_DOWN_ONE_FAULT_BIT] = i_step_down_fault;
    fault_two_in = 8'h00;
    fault_two_in[rail_status_pkg::AUX_REG_ONE_FAULT_BIT]   = i_aux_reg_one_fault;
    fault_two_in[rail_status_pkg::TERMINATION_FAULT_BIT]   = i_termination_fault;
    fault_two_in[rail_status_pkg::SWITCH_B_TWO_FAULT_BIT]  = i_switch_b_two_fault;
    fault_two_in[rail_status_pkg::SWITCH_B_ONE_FAULT_BIT]  = i_switch_b_one_fault;
    fault_two_in[rail_status_pkg::AUX_REG_THREE_FAULT_BIT] = i_aux_reg_three_fault;
  end

  // Writes to the power-good offset decode to nothing
  assign wr_fault_one = i_wr_en && (i_addr == rail_status_pkg::POWER_FAULT_STATUS_ONE_ADDR);
  assign wr_fault_two = i_wr_en && (i_addr == rail_status_pkg::POWER_FAULT_STATUS_TWO_ADDR);

  fault_latch_byte #(
    .MASK      (rail_status_pkg::POWER_FAULT_STATUS_ONE_MASK),
    .RST_VALUE (rail_status_pkg::POWER_FAULT_STATUS_ONE_RST)
  ) u_fault_one (
    .i_clk      (i_clk),
    .i_rst_b    (i_rst_b),
    .i_fault    (fault_one_in),
    .i_clr_en   (wr_fault_one),
    .i_clr_data (i_wr_data),
    .o_flags    (o_power_fault_status_one)
  );

  fault_latch_byte #(
    .MASK      (rail_status_pkg::POWER_FAULT_STATUS_TWO_MASK),
    .RST_VALUE (rail_status_pkg::POWER_FAULT_STATUS_TWO_RST)
  ) u_fault_two (
    .i_clk      (i_clk),
    .i_rst_b    (i_rst_b),
    .i_fault    (fault_two_in),
    .i_clr_en   (wr_fault_two),
    .i_clr_data (i_wr_data),
    .o_flags    (o_power_fault_status_two)
  );

  // Read mux; unmapped offsets return zero with no hit
  always_comb begin
    rd_data_next = rd_data_reg;
    rd_hit_next  = 1'b0;
    if (i_rd_en) begin
      rd_hit_next = 1'b1;
      case (i_addr)
        rail_status_pkg::POWER_GOOD_STATUS_TWO_ADDR: begin
          rd_data_next = good_reg;
        end
        rail_status_pkg::POWER_FAULT_STATUS_ONE_ADDR: begin
          rd_data_next = o_power_fault_status_one;
        end
        rail_status_pkg::POWER_FAULT_STATUS_TWO_ADDR: begin
          rd_data_next = o_power_fault_status_two;
        end
        default: begin
          rd_data_next = 8'h00;
          rd_hit_next  = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      rd_data_reg <= 8'h00;
      rd_hit_reg  <= 1'b0;
    end else begin
      rd_data_reg <= rd_data_next;
      rd_hit_reg  <= rd_hit_next;
    end
  end

  assign o_rd_data = rd_data_reg;
  assign o_rd_hit  = rd_hit_reg;

endmodule : rail_status_fault_regs
`default_nettype wire

/* File: hdl/rail_status_pkg.sv */
// Purpose: Shared constants for the rail status and fault register bank
// Assumes: Byte-wide register port, register offsets as printed
// Notes:   Field positions give the bit index of each rail flag
package rail_status_pkg;

  // Register offsets
  localparam logic [7:0] POWER_GOOD_STATUS_TWO_ADDR  = 8'hB1;
  localparam logic [7:0] POWER_FAULT_STATUS_ONE_ADDR = 8'hB2;
  localparam logic [7:0] POWER_FAULT_STATUS_TWO_ADDR = 8'hB3;

  // Reset values
  localparam logic [7:0] POWER_GOOD_STATUS_TWO_RST   = 8'h00;
  localparam logic [7:0] POWER_FAULT_STATUS_ONE_RST  = 8'h00;
  localparam logic [7:0] POWER_FAULT_STATUS_TWO_RST  = 8'h00;

  // Implemented bits
  localparam logic [7:0] POWER_GOOD_STATUS_TWO_MASK  = 8'h3F;
  localparam logic [7:0] POWER_FAULT_STATUS_ONE_MASK = 8'hFF;
  localparam logic [7:0] POWER_FAULT_STATUS_TWO_MASK = 8'h1F;

  // Power-good two fields
  localparam int FIVE_VOLT_REG_GOOD_BIT  = 5;
  localparam int AUX_REG_ONE_GOOD_BIT    = 4;
  localparam int TERMINATION_GOOD_BIT    = 3;
  localparam int SWITCH_B_TWO_GOOD_BIT   = 2;
  localparam int SWITCH_B_ONE_GOOD_BIT   = 1;
  localparam int AUX_REG_THREE_GOOD_BIT  = 0;

  // Fault one fields; step-down rails one to six sit at bits 0 to 5
  localparam int AUX_REG_TWO_FAULT_BIT   = 7;
  localparam int SWITCH_A_ONE_FAULT_BIT  = 6;
  localparam int STEP_DOWN_ONE_FAULT_BIT = 0;
  localparam int STEP_DOWN_SIX_FAULT_BIT = 5;

  // Fault two fields
  localparam int AUX_REG_ONE_FAULT_BIT   = 4;
  localparam int TERMINATION_FAULT_BIT   = 3;
  localparam int SWITCH_B_TWO_FAULT_BIT  = 2;
  localparam int SWITCH_B_ONE_FAULT_BIT  = 1;
  localparam int AUX_REG_THREE_FAULT_BIT = 0;

endpackage : rail_status_pkg

/* File: hdl/fault_latch_byte.sv */
// Purpose: Eight sticky fault flags with write-one-to-clear
// Assumes: Fault inputs are synchronous levels, high while out of regulation
// Notes:   Unimplemented positions given by the mask stay at zero
`timescale 1ns/100ps
`default_nettype none
module fault_latch_byte #(
  parameter logic [7:0] MASK      = 8'hFF,
  parameter logic [7:0] RST_VALUE = 8'h00
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  // Fault events and clear strobe
  input  wire logic [7:0] i_fault,
  input  wire logic       i_clr_en,
  input  wire logic [7:0] i_clr_data,
  // Flag state
  output logic      [7:0] o_flags
);

  logic [7:0] flags_reg;
  logic [7:0] flags_next;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bit
      always_comb begin
        if (!MASK[gi]) begin
          flags_next[gi] = 1'b0;
        end else if (i_fault[gi]) begin
          // A new fault wins over a clear in the same cycle
          flags_next[gi] = 1'b1;
        end else if (i_clr_en && i_clr_data[gi]) begin
          flags_next[gi] = 1'b0;
        end else begin
          flags_next[gi] = flags_reg[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      flags_reg <= RST_VALUE;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign o_flags = flags_reg;

endmodule : fault_latch_byte
`default_nettype wire

/* File: sim/rail_status_sva.sv */
// Purpose: Assertions on the rail status register bank ports
// Assumes: Single clock, synchronous active-low reset
// Notes:   Set wins over clear when both land on one edge
`timescale 1ns/100ps
`default_nettype none
module rail_status_sva (
  input wire logic       i_clk, i_rst_b, i_wr_en, i_rd_en, o_rd_hit,
  input wire logic [7:0] i_addr, i_wr_data, o_rd_data,
  input wire logic       i_five_volt_reg_good, i_aux_reg_one_good, i_termination_good,
  input wire logic       i_switch_b_two_good, i_switch_b_one_good, i_aux_reg_three_good,
  input wire logic       i_aux_reg_two_fault, i_switch_a_one_fault, i_aux_reg_one_fault,
  input wire logic       i_termination_fault, i_switch_b_two_fault, i_switch_b_one_fault,
  input wire logic       i_aux_reg_three_fault,
  input wire logic [5:0] i_step_down_fault,
  input wire logic [7:0] o_power_fault_status_one, o_power_fault_status_two
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  wire logic [5:0] pg = {i_five_volt_reg_good, i_aux_reg_one_good, i_termination_good,
                         i_switch_b_two_good, i_switch_b_one_good, i_aux_reg_three_good};
  wire logic [7:0] f1 = {i_aux_reg_two_fault, i_switch_a_one_fault, i_step_down_fault};
  wire logic [7:0] f2 = {3'h0, i_aux_reg_one_fault, i_termination_fault,
                         i_switch_b_two_fault, i_switch_b_one_fault, i_aux_reg_three_fault};
  wire logic [7:0] c1 = (i_wr_en && i_addr == 8'hB2) ? i_wr_data : 8'h00;
  wire logic [7:0] c2 = (i_wr_en && i_addr == 8'hB3) ? i_wr_data : 8'h00;
  wire logic [7:0] q1 = o_power_fault_status_one;
  wire logic [7:0] q2 = o_power_fault_status_two;
  wire logic       hit = i_addr inside {8'hB1, 8'hB2, 8'hB3};
  sequence s_rd(logic [7:0] a);
    i_rd_en && i_addr == a;
  endsequence
  // Status byte lags the pins by one sample, so a read right after reset is skipped
  AST_PG: assert property (s_rd(8'hB1) ##0 $past(i_rst_b)
    |=> o_rd_data == {2'h0, $past(pg, 2)}) else $error("power-good read wrong");
  AST_HIT: assert property (i_rd_en && hit |=> o_rd_hit)
    else $error("mapped read gave no hit");
  AST_MISS: assert property (i_rd_en && !hit |=> !o_rd_hit && o_rd_data == 8'h00)
    else $error("unmapped read wrong");
  AST_RD1: assert property (s_rd(8'hB2) |=> o_rd_data == $past(q1))
    else $error("fault one read wrong");
  AST_RD2: assert property (s_rd(8'hB3) |=> o_rd_data == $past(q2))
    else $error("fault two read wrong");
  AST_F1: assert property (1'b1 |=> q1 == (($past(q1) & ~$past(c1)) | $past(f1)))
    else $error("fault one flags wrong");
  AST_F2: assert property (1'b1 |=> q2 == (($past(q2) & ~$past(c2)) | $past(f2)))
    else $error("fault two flags wrong");
  AST_RSVD: assert property (q2[7:5] == 3'h0) else $error("reserved bits set");
endmodule : rail_status_sva
bind rail_status_fault_regs rail_status_sva u_sva (.*);
`default_nettype wire

/* File: sim/host_port_model.sv */
// Purpose: Host side of the byte register port
// Assumes: One strobe cycle per access, read answer one cycle later
// Notes:   Released lines show the inverse of their last value
`timescale 1ns/100ps
`default_nettype none
module host_port_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rd_data,
  input  wire logic       i_rd_hit,
  output logic      [7:0] o_addr,
  output logic            o_wr_en,
  output logic      [7:0] o_wr_data,
  output logic            o_rd_en
);
  initial begin
    o_addr = 8'h00;
    o_wr_en = 1'b0;
    o_wr_data = 8'h00;
    o_rd_en = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wr_en <= 1'b1;
    o_wr_data <= d;
    @(posedge i_clk);
    o_wr_en <= 1'b0;
    o_addr <= ~a;
    o_wr_data <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(posedge i_clk);
    o_addr <= a;
    o_rd_en <= 1'b1;
    @(posedge i_clk);
    o_rd_en <= 1'b0;
    o_addr <= ~a;
    // The hit stands for one cycle after the strobe edge and the data holds until the next read, so take both at the next rising edge
    @(posedge i_clk);
    d = i_rd_data;
    h = i_rd_hit;
  endtask : rd
endmodule : host_port_model
`default_nettype wire

/* File: sim/rail_status_fault_regs_tb_top.sv */
// Purpose: Directed register tests of the rail status bank
// Assumes: Rail levels change only on rising clock edges
// Notes:   Fault pulses last one cycle to prove the flags stick
`timescale 1ns/100ps
`default_nettype none
module rail_status_fault_regs_tb_top;
  logic       i_clk = 1'b0;
  logic       i_rst_b = 1'b0;
  logic [7:0] i_addr, i_wr_data, o_rd_data, o_power_fault_status_one, o_power_fault_status_two;
  logic       i_wr_en, i_rd_en, o_rd_hit, h;
  logic [7:0] d, a, q, f1 = 8'h00, f2 = 8'h00;
  logic [5:0] good = 6'h00;
  wire logic  i_five_volt_reg_good, i_aux_reg_one_good, i_termination_good, i_switch_b_two_good;
  wire logic  i_switch_b_one_good, i_aux_reg_three_good, i_aux_reg_two_fault, i_switch_a_one_fault;
  wire logic  i_aux_reg_one_fault, i_termination_fault, i_switch_b_two_fault, i_switch_b_one_fault;
  wire logic  i_aux_reg_three_fault;
  wire logic [5:0] i_step_down_fault;
  int         n_errors = 0;
  int         total_checks = 0;
  assign {i_five_volt_reg_good, i_aux_reg_one_good, i_termination_good, i_switch_b_two_good,
          i_switch_b_one_good, i_aux_reg_three_good} = good;
  assign {i_aux_reg_two_fault, i_switch_a_one_fault, i_step_down_fault} = f1;
  assign {i_aux_reg_one_fault, i_termination_fault, i_switch_b_two_fault, i_switch_b_one_fault,
          i_aux_reg_three_fault} = f2[4:0];
  always #25 i_clk = ~i_clk;
  rail_status_fault_regs dut (.*);
  host_port_model host (.i_clk(i_clk), .i_rd_data(o_rd_data), .i_rd_hit(o_rd_hit),
    .o_addr(i_addr), .o_wr_en(i_wr_en), .o_wr_data(i_wr_data), .o_rd_en(i_rd_en));
  task automatic rdchk(input string nm, input logic [7:0] ad, input logic [7:0] e);
    host.rd(ad, d, h);
    total_checks += 2;
    if (d !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, d);
    end
    if (h !== (ad inside {8'hB1, 8'hB2, 8'hB3})) begin
      n_errors++;
      $display("wrong value %s hit expected %b seen %b", nm, ~h, h);
    end
  endtask : rdchk
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (2) @(posedge i_clk);
    rdchk("good two reset", 8'hB1, 8'h00);
    rdchk("fault one reset", 8'hB2, 8'h00);
    rdchk("fault two reset", 8'hB3, 8'h00);
    $display("test reset done");
    for (int k = 0; k < 6; k++) begin
      @(posedge i_clk) good <= 6'h01 << k;
      host.wr(8'hB1, 8'hFF);
      rdchk("good two", 8'hB1, 8'h01 << k);
    end
    @(posedge i_clk) good <= 6'h00;
    $display("test power good done");
    // Writing zeros and reserved ones must not touch a flag; only its own 1 clears it
    for (int r = 0; r < 2; r++) begin
      a = (r == 0) ? 8'hB2 : 8'hB3;
      for (int k = 0; k < 8 - 3 * r; k++) begin
        @(posedge i_clk);
        if (r == 0) f1 <= 8'h01 << k; else f2 <= 8'h01 << k;
        @(posedge i_clk);
        f1 <= 8'h00;
        f2 <= 8'h00;
        host.wr(a, ~(8'h01 << k));
        rdchk("fault kept", a, 8'h01 << k);
        q = (r == 0) ? o_power_fault_status_one : o_power_fault_status_two;
        total_checks++;
        if (q !== 8'h01 << k) begin
          n_errors++;
          $display("wrong value flag output expected %h seen %h", 8'h01 << k, q);
        end
        host.wr(a, 8'hFF);
        rdchk("fault cleared", a, 8'h00);
      end
    end
    $display("test fault flags done");
    // The fault pulse stands only at the edge that takes the clear write
    fork
      host.wr(8'hB2, 8'hFF);
      begin
        @(posedge i_clk) f1 <= 8'h80;
        @(posedge i_clk) f1 <= 8'h00;
      end
    join
    rdchk("set over clear", 8'hB2, 8'h80);
    host.wr(8'hB4, 8'hFF);
    rdchk("unmapped", 8'hB4, 8'h00);
    rdchk("flag after unmapped", 8'hB2, 8'h80);
    $display("test unmapped done");
    // A reset in mid-run must drop a flag that is still set
    @(posedge i_clk) i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rdchk("fault one after reset", 8'hB2, 8'h00);
    $display("test mid-run reset done");
    test_done();
  end
  initial begin
    repeat (3000) @(posedge i_clk);
    n_errors++;
    test_done();
  end
endmodule : rail_status_fault_regs_tb_top
`default_nettype wire
